// file: logic/port_pin_data_io_change_detect.sv
// Operation
// - eight bidirectional pins, one bit each register
// - direction one floats pin, zero drives latch
// - latch register reads back latched value
// - clearing bit seven enables pull-ups on all undriven pins
// - pull-up off while pin drives
// - any reset leaves pull-ups disabled
// - reset: lower five analog, read zero
// - config bit one makes lower pins digital
// - only upper input pins are compared
// - mismatch with value at last port access sets flag
// - port change wakes device from sleep
// - port access refreshes reference, except move
// - persisting mismatch keeps setting the flag
// - enabled analog channels read as low
// - CAN transmit overrides pin two direction
// - programming entry overrides pin five driver
`timescale 1ns/1ps
`default_nettype none
module port_pin_data_io_change_detect
    import port_pin_data_pkg::*;
(
    input wire logic mclk, // core clock, 50 MHz
    input wire logic arst_n, // power-on / device reset
    input wire cpu_req_t cpu_req, // core register access
    input wire logic [7:0] config_byte_three_high, // config fuses
    input wire logic ana_cfg_wr, // analog select update
    input wire logic [4:0] ana_cfg_data, // new analog select
    input wire pin_ovr_t pin_ovr, // peripheral overrides
    input wire logic [7:0] pin_in, // pin levels
    output logic [7:0] pin_out_r, // pin output values
    output logic [7:0] pin_oe_r, // pin drive enables
    output logic [7:0] pullup_en_r, // weak pull-up enables
    output logic [7:0] rdata_r, // read data
    output logic port_change_flag_r, // change flag
    output logic wake_r, // wake request
    output logic [4:0] analog_en_r, // lower pins analog
    output logic can_receive_pin_r // CAN receive level
);

    // an analog pin reads as low
    function automatic logic [7:0] mask_analog(
        input logic [7:0] pins,
        input logic [4:0] ana
    );
        mask_analog = pins & ~{3'h0, ana};
    endfunction

    function automatic logic is_sel(
        input cpu_req_t req,
        input logic [2:0] sel
    );
        is_sel = req.sel == sel;
    endfunction

    logic [7:0] port_output_latch;
    logic [7:0] port_direction;
    logic pullup_disable_n;
    logic [7:0] pin_q_r;
    logic [3:0] ref_r;
    boot_state_t boot_r;
    logic [7:0] pin_rd;
    logic mismatch;
    logic data_access;
    logic [7:0] oe_nxt;
    logic [7:0] out_nxt;
    logic [7:0] pu_nxt;

    // pin sample stage
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_q_r <= BYTE_ZERO;
        end
        else
        begin
            pin_q_r <= pin_in;
        end
    end

    assign pin_rd = mask_analog(pin_q_r, analog_en_r);
    assign data_access = (cpu_req.rd | cpu_req.wr)
        & is_sel(cpu_req, REG_PIN_DATA) & ~cpu_req.mem_move;

    // output latch, written through data or latch select
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            port_output_latch <= LATCH_RST;
        end
        else if (cpu_req.wr && (is_sel(cpu_req, REG_PIN_DATA)
            || is_sel(cpu_req, REG_LATCH)))
        begin
            port_output_latch <= cpu_req.wdata;
        end
    end

    // direction, inputs after reset
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            port_direction <= DIR_RST;
        end
        else if (cpu_req.wr && is_sel(cpu_req, REG_DIRECTION))
        begin
            port_direction <= cpu_req.wdata;
        end
    end

    // global pull-up control, active low
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pullup_disable_n <= PULLUP_DIS_RST;
        end
        else if (cpu_req.wr && is_sel(cpu_req, REG_IC_TWO))
        begin
            pullup_disable_n <= cpu_req.wdata[PULLUP_BIT];
        end
    end

    // analog select: fuse applied once after reset release,
    // since a port value may not be loaded under async reset
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            boot_r <= ST_BOOT;
            analog_en_r <= ANA_ALL;
        end
        else
        begin
            case (boot_r)
                ST_BOOT:
                begin
                    boot_r <= ST_RUN;
                    if (config_byte_three_high[ANA_CFG_BIT])
                    begin
                        analog_en_r <= ANA_NONE;
                    end
                end
                ST_RUN:
                begin
                    if (ana_cfg_wr)
                    begin
                        analog_en_r <= ana_cfg_data;
                    end
                end
                default:
                begin
                    boot_r <= ST_BOOT;
                end
            endcase
        end
    end

    // compare reference, refreshed on data-register access
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ref_r <= NIBBLE_ZERO;
        end
        else if (data_access)
        begin
            ref_r <= pin_rd[7:4];
        end
    end

    // outputs driven as pins are excluded from comparison
    assign mismatch = |((pin_rd[7:4] ^ ref_r)
        & port_direction[7:4]);

    // set wins over a software clear in the same cycle
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            port_change_flag_r <= 1'b0;
        end
        else if (mismatch)
        begin
            port_change_flag_r <= 1'b1;
        end
        else if (cpu_req.wr && is_sel(cpu_req, REG_IC_MAIN))
        begin
            port_change_flag_r <= cpu_req.wdata[FLAG_BIT];
        end
    end

    // wake stays up while the mismatch lasts
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wake_r <= 1'b0;
        end
        else
        begin
            wake_r <= mismatch;
        end
    end

    // read mux; unmapped selects return zero
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_r <= BYTE_ZERO;
        end
        else if (cpu_req.rd)
        begin
            case (cpu_req.sel)
                REG_PIN_DATA: rdata_r <= pin_rd;
                REG_LATCH: rdata_r <= port_output_latch;
                REG_DIRECTION: rdata_r <= port_direction;
                REG_IC_TWO: rdata_r <= {pullup_disable_n, 7'h00};
                REG_IC_MAIN: rdata_r <= {7'h00, port_change_flag_r};
                default: rdata_r <= BYTE_ZERO;
            endcase
        end
    end

    // pin drivers with peripheral overrides
    always_comb
    begin
        oe_nxt = ~port_direction;
        out_nxt = port_output_latch;
        if (pin_ovr.can_en)
        begin
            oe_nxt[CAN_TX_PIN] = 1'b1;
            out_nxt[CAN_TX_PIN] = pin_ovr.can_tx;
        end
        if (pin_ovr.lvp_en)
        begin
            oe_nxt[LVP_PIN] = 1'b0;
        end
        pu_nxt = pullup_disable_n ? BYTE_ZERO : ~oe_nxt;
    end

    // registered pad controls
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_oe_r <= BYTE_ZERO;
            pin_out_r <= BYTE_ZERO;
            pullup_en_r <= BYTE_ZERO;
        end
        else
        begin
            pin_oe_r <= oe_nxt;
            pin_out_r <= out_nxt;
            pullup_en_r <= pu_nxt;
        end
    end

    // receive line relies on software keeping pin three input
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            can_receive_pin_r <= 1'b1;
        end
        else
        begin
            can_receive_pin_r <= pin_q_r[CAN_RX_PIN];
        end
    end

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence s_data_access;
        cpu_req.rd && is_sel(cpu_req, REG_PIN_DATA)
            && !cpu_req.mem_move;
    endsequence

    sequence s_latch_read;
        cpu_req.rd && is_sel(cpu_req, REG_LATCH);
    endsequence

    // software clear of the change flag
    sequence s_flag_clear;
        cpu_req.wr && is_sel(cpu_req, REG_IC_MAIN) && !cpu_req.wdata[FLAG_BIT];
    endsequence

    a_input_hiz: assert property (
        port_direction[6] |=> !pin_oe_r[6])
        else $error("input pin is driven");

    a_output_drive: assert property (
        !port_direction[7] |=> pin_oe_r[7]
            && pin_out_r[7] == $past(port_output_latch[7]))
        else $error("output pin not driving latch");

    a_latch_readback: assert property (
        s_latch_read |=> rdata_r == $past(port_output_latch))
        else $error("latch read not latch value");

    a_pullup_global: assert property (
        pullup_disable_n |=> pullup_en_r == BYTE_ZERO)
        else $error("pull-up on while disabled");

    a_pullup_output: assert property (
        (pullup_en_r & pin_oe_r) == BYTE_ZERO)
        else $error("pull-up on a driving pin");

    a_reset_pullup: assert property (
        boot_r == ST_BOOT |-> pullup_en_r == BYTE_ZERO)
        else $error("pull-up on after reset");

    a_boot_analog: assert property (
        $rose(boot_r) |-> analog_en_r ==
            ($past(config_byte_three_high[ANA_CFG_BIT])
                ? ANA_NONE : ANA_ALL))
        else $error("lower pins wrong after reset");

    a_output_excluded: assert property (
        port_direction[7:4] == NIBBLE_ZERO |-> !mismatch)
        else $error("output pin joined comparison");

    a_change_set: assert property (
        mismatch |=> port_change_flag_r && wake_r)
        else $error("mismatch did not set flag");

    a_mismatch_hold: assert property (
        mismatch ##0 s_flag_clear |=> port_change_flag_r)
        else $error("flag cleared during mismatch");

    a_ref_refresh: assert property (
        s_data_access |=> ref_r == $past(pin_rd[7:4]))
        else $error("reference not refreshed");

    a_analog_low: assert property (
        cpu_req.rd && is_sel(cpu_req, REG_PIN_DATA)
            && analog_en_r[0] |=> !rdata_r[0])
        else $error("analog pin read high");

    a_can_drive: assert property (
        pin_ovr.can_en |=> pin_oe_r[CAN_TX_PIN]
            && pin_out_r[CAN_TX_PIN] == $past(pin_ovr.can_tx))
        else $error("CAN transmit not on pin");

    a_lvp_float: assert property (
        pin_ovr.lvp_en |=> !pin_oe_r[LVP_PIN])
        else $error("pin five driven in programming");

endmodule
`default_nettype wire

// file: logic/port_pin_data_pkg.sv
`default_nettype none
package port_pin_data_pkg;
    // register selects on the core access port
    localparam logic [2:0] REG_PIN_DATA = 3'h0;
    localparam logic [2:0] REG_LATCH = 3'h1;
    localparam logic [2:0] REG_DIRECTION = 3'h2;
    localparam logic [2:0] REG_IC_TWO = 3'h3;
    localparam logic [2:0] REG_IC_MAIN = 3'h4;

    // field positions
    localparam int PULLUP_BIT = 7;
    localparam int FLAG_BIT = 0;
    localparam int ANA_CFG_BIT = 1;
    localparam int CAN_TX_PIN = 2;
    localparam int CAN_RX_PIN = 3;
    localparam int LVP_PIN = 5;

    // reset values
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic PULLUP_DIS_RST = 1'b1;
    localparam logic [4:0] ANA_ALL = 5'h1F;
    localparam logic [4:0] ANA_NONE = 5'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [3:0] NIBBLE_ZERO = 4'h0;

    // one core access, taken in a single cycle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] sel;
        logic [7:0] wdata;
        logic mem_move;
    } cpu_req_t;

    // peripheral overrides on the pins
    typedef struct packed {
        logic can_en;
        logic can_tx;
        logic lvp_en;
    } pin_ovr_t;

    typedef enum logic [0:0] {
        ST_BOOT = 1'b0,
        ST_RUN = 1'b1
    } boot_state_t;
endpackage
`default_nettype wire

// file: tb/board_pins.sv
`timescale 1ns/1ps
`default_nettype none
module board_pins
(
    input wire logic mclk, // core clock
    input wire logic [7:0] pin_out_r, // pad values
    input wire logic [7:0] pin_oe_r, // pad drive enables
    input wire logic [7:0] pullup_en_r, // weak pull-ups
    input wire logic [7:0] ext_val, // board drive value
    input wire logic [7:0] ext_drv, // board drives pin
    output logic [7:0] pin_level // resolved levels
);
    logic [7:0] float_r = 8'h00;
    // undriven pins wander so a stale value never passes
    always_ff @(posedge mclk)
        float_r <= ~float_r;
    // pad first, then board, then pull-up
    always_comb
        for (int i = 0; i < 8; i++)
            pin_level[i] = pin_oe_r[i] ? pin_out_r[i] :
                ed_sel(ext_drv[i], ext_val[i], pullup_en_r[i], float_r[i]);
    function automatic logic ed_sel(input logic dv, v, p, f);
        return dv ? v : (p ? 1'b1 : f);
    endfunction
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import port_pin_data_pkg::*;
    logic mclk = 1'b0;
    logic arst_n;
    cpu_req_t req;
    logic [7:0] cfg;
    logic acw;
    logic [4:0] acd;
    pin_ovr_t ovr;
    logic [7:0] pins, po, oe, pu, rd, ev, ed, d, l, e;
    logic flag, wake, crx;
    logic [4:0] an;
    int n_fail = 0;
    int n_compared = 0;

    always #10 mclk = ~mclk;

    port_pin_data_io_change_detect DUT (.mclk(mclk), .arst_n(arst_n),
        .cpu_req(req), .config_byte_three_high(cfg), .ana_cfg_wr(acw),
        .ana_cfg_data(acd), .pin_ovr(ovr), .pin_in(pins),
        .pin_out_r(po), .pin_oe_r(oe), .pullup_en_r(pu), .rdata_r(rd),
        .port_change_flag_r(flag), .wake_r(wake), .analog_en_r(an),
        .can_receive_pin_r(crx));

    board_pins board (.mclk(mclk), .pin_out_r(po), .pin_oe_r(oe),
        .pullup_en_r(pu), .ext_val(ev), .ext_drv(ed), .pin_level(pins));

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // one-cycle access, launched just after an edge
    task automatic acc(input logic r, w, input logic [2:0] s,
        input logic [7:0] v, input logic m);
        req = '{rd: r, wr: w, sel: s, wdata: v, mem_move: m};
        @(posedge mclk);
        #1;
        req = '0;
        // one quiet edge so back-to-back calls never retime req
        @(posedge mclk);
        #1;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        if (n_fail == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic rst;
        arst_n = 1'b0;
        idle(5);
        arst_n = 1'b1;
        idle(2);
    endtask

    // level seen on a data read: pads loop back for outputs
    function automatic logic [7:0] pin_read(input logic [7:0] x, y, z);
        return (x & y) | (z & ~y);
    endfunction

    initial
    begin
        #200000;
        n_fail++;
        complete_run();
    end

    initial
    begin
        void'($urandom(92));
        req = '0;
        cfg = 8'h00;
        acw = 1'b0;
        acd = 5'h00;
        ovr = '0;
        ev = 8'hFF;
        ed = 8'hFF;
        rst();
        check({3'h0, an}, 8'h1F);
        check(pu, 8'h00);
        acc(1, 0, REG_PIN_DATA, 8'h00, 0);
        idle(1);
        check(rd, 8'hE0);
        acc(1, 0, REG_IC_TWO, 8'h00, 0);
        check(rd, 8'h80);
        acw = 1'b1;
        idle(1);
        acw = 1'b0;
        idle(2);
        check({3'h0, an}, 8'h00);
        // all pull-ups on, then lose them on driven pins
        acc(0, 1, REG_IC_TWO, 8'h00, 0);
        idle(3);
        check(pu, 8'hFF);
        acc(1, 0, REG_IC_TWO, 8'h00, 0);
        check(rd, 8'h00);
        acc(0, 1, REG_DIRECTION, 8'h0F, 0);
        idle(3);
        check(pu, 8'h0F);
        for (int i = 0; i < 6; i++)
        begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            l = 8'($urandom);
            e = 8'($urandom);
            acc(0, 1, REG_DIRECTION, d, 0);
            // odd passes write the latch through the data register
            acc(0, 1, i[0] ? REG_PIN_DATA : REG_LATCH, l, 0);
            ev = e;
            idle(3);
            check(oe, ~d);
            check(po & ~d, l & ~d);
            check(pu, d);
            acc(1, 0, REG_LATCH, 8'h00, 0);
            idle(1);
            check(rd, l);
            acc(1, 0, REG_DIRECTION, 8'h00, 0);
            check(rd, d);
            acc(1, 0, REG_PIN_DATA, 8'h00, 0);
            idle(1);
            check(rd, pin_read(e, d, l));
        end
        // change detect on inputs; no polling meanwhile
        acc(0, 1, REG_DIRECTION, 8'hFF, 0);
        idle(2);
        acc(1, 0, REG_PIN_DATA, 8'h00, 0);
        acc(0, 1, REG_IC_MAIN, 8'h00, 0);
        idle(3);
        check({7'h0, flag}, 8'h00);
        ev[7] = ~ev[7];
        idle(3);
        check({6'h0, wake, flag}, 8'h03);
        acc(1, 0, REG_IC_MAIN, 8'h00, 0);
        check(rd, 8'h01);
        acc(0, 1, REG_IC_MAIN, 8'h00, 0);
        idle(3);
        check({7'h0, flag}, 8'h01);
        acc(1, 0, REG_PIN_DATA, 8'h00, 1);
        idle(3);
        check({7'h0, wake}, 8'h01);
        acc(1, 0, REG_PIN_DATA, 8'h00, 0);
        idle(3);
        check({7'h0, wake}, 8'h00);
        acc(0, 1, REG_IC_MAIN, 8'h00, 0);
        idle(3);
        check({7'h0, flag}, 8'h00);
        // driven upper pins and lower pins never compare
        acc(0, 1, REG_DIRECTION, 8'h0F, 0);
        // driven upper levels surely differ from the reference
        acc(0, 1, REG_LATCH, ~ev, 0);
        ev[3:0] = ~ev[3:0];
        idle(4);
        check({6'h0, wake, flag}, 8'h00);
        // peripheral overrides; pin three stays input
        acc(0, 1, REG_DIRECTION, 8'h00, 0);
        acc(0, 1, REG_DIRECTION, 8'hFF, 0);
        for (int i = 0; i < 2; i++)
        begin
            ovr = '{can_en: 1'b1, can_tx: i[0], lvp_en: 1'b0};
            ev[3] = ~i[0];
            idle(4);
            check({6'h0, oe[2], po[2]}, {6'h0, 1'b1, i[0]});
            check({7'h0, crx}, {7'h0, ~i[0]});
        end
        ovr = '{can_en: 1'b0, can_tx: 1'b0, lvp_en: 1'b1};
        acc(0, 1, REG_DIRECTION, 8'h00, 0);
        idle(3);
        check({7'h0, oe[5]}, 8'h00);
        ovr = '0;
        // reset again with the digital-pins fuse set
        cfg = 8'h02;
        rst();
        check({3'h0, an}, 8'h00);
        check(pu, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
